// >>> rtl/crs_pkg.sv
// crs_pkg: shared types and constants for the clock reference selector
// assumes a 40 MHz ref_clk; the chatter and watchdog counts derive from it
package crs_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CHATTER_S = 10;            // anti-chatter time in seconds
  localparam longint unsigned CHATTER_CYC = longint'(CHATTER_S) * CLK_HZ;
  localparam int unsigned WDOG_US = 100;              // watchdog window in microseconds
  localparam int unsigned WDOG_CYC = WDOG_US * (CLK_HZ / 1000000);
  localparam int unsigned SELFTEST_CYC = 16;          // self-test sequence length
  localparam int unsigned HIST_DEPTH = 16;            // quality history entries
  localparam int unsigned LOCK_CYC = 64;              // in-spec phase cycles to call lock

  // software commands over the parallel port
  typedef enum logic [1:0] {
    CMD_FREE_RUN = 2'h0,
    CMD_TRACK_PRI = 2'h1,
    CMD_TRACK_SEC = 2'h2,
    CMD_NONE = 2'h3
  } crs_cmd_t;

  typedef enum logic [1:0] {
    MODE_FREE_RUN = 2'h0,
    MODE_TRACKING = 2'h1,
    MODE_LOCKED = 2'h2,
    MODE_HOLDOVER = 2'h3
  } crs_mode_t;

  // per-reference quality as judged outside this block
  typedef struct packed {
    logic present;   // signal seen
    logic in_spec;   // quality good enough to follow
    logic burst;     // abrupt change from an error burst
    logic near_lock; // frequency difference within lock window
  } crs_ref_qual_t;

  // status word returned over the cpu port
  typedef struct packed {
    crs_mode_t mode;
    logic sel_sec;
    logic pri_ok;
    logic sec_ok;
    logic test_done;
    logic test_fail;
  } crs_status_t;
endpackage

// >>> rtl/crs_hist_mem.sv
// crs_hist_mem: small quality history memory, one bit per entry per reference
// assumes a single clock; read data are registered
`timescale 1ns/1ps
module crs_hist_mem
  import crs_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH,
  parameter int AW = $clog2(HIST_DEPTH)
) (
  input wire logic clk,           // block clock
  input wire logic rst_n,         // synchronised reset
  input wire logic wr_en,         // write strobe
  input wire logic [AW-1:0] addr, // entry index
  input wire logic [1:0] wr_data, // {sec_ok, pri_ok}
  output logic [1:0] rd_data      // registered read of addr
);
  logic [1:0] mem [DEPTH];
  logic [1:0] next_rd_data;

  // read the entry being overwritten, so the caller sees the oldest sample
  always_comb begin
    next_rd_data = mem[addr];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 2'h0;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // storage has no reset; a valid-count in the caller says what is filled
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
  end
endmodule

// >>> rtl/crs_selector.sv
// crs_selector: reference selection and mode control of the clock controller
// assumes reference quality flags are judged upstream, synchronous to ref_clk
`timescale 1ns/1ps
module crs_selector
  import crs_pkg::*;
#(
  parameter longint unsigned CHATTER_CYCLES = CHATTER_CYC,
  parameter int unsigned WDOG_CYCLES = WDOG_CYC
) (
  input wire logic ref_clk,                 // 40 MHz clock
  input wire logic rst_n,                   // async reset, active low
  input wire logic enable,                  // controller enabled by software
  input wire logic cmd_valid,               // cpu port command strobe
  input wire crs_cmd_t cmd,                 // cpu port command
  input wire logic ext_src,                 // 1: external timing interface refs
  input wire crs_ref_qual_t trunk_pri,      // primary from digital_trunk_card
  input wire crs_ref_qual_t trunk_sec,      // secondary from digital_trunk_card
  input wire crs_ref_qual_t ext_pri,        // primary from external interface
  input wire crs_ref_qual_t ext_sec,        // secondary from external interface
  input wire logic wdog_kick,               // controller service pulse
  input wire logic test_pass,               // self-test datapath result
  output crs_status_t status,               // status readable on cpu port
  output logic sel_sec,                     // 1: secondary drives the loop
  output logic hold_en,                     // freeze loop at stored state
  output logic primary_ref_backplane_line_oe, // this card drives the line
  output logic ctrl_reset                   // watchdog reset of controller
);
  typedef enum logic [1:0] {ST_SELFTEST, ST_RUN} crs_phase_t;

  logic rst_s1, rst_s2;
  crs_phase_t phase, next_phase;
  crs_mode_t mode, next_mode;
  crs_cmd_t cur_cmd, next_cur_cmd;
  logic sel, next_sel;
  logic [63:0] chat_cnt, next_chat_cnt;
  logic [31:0] wd_cnt, next_wd_cnt;
  logic wd_rst, next_wd_rst;
  logic [4:0] st_cnt, next_st_cnt;
  logic t_done, next_t_done, t_fail, next_t_fail;
  logic [6:0] lock_cnt, next_lock_cnt;
  logic [$clog2(HIST_DEPTH):0] hist_fill, next_hist_fill;
  logic [$clog2(HIST_DEPTH)-1:0] hist_ptr, next_hist_ptr;
  logic [1:0] hist_rd;
  crs_ref_qual_t q_pri, q_sec, q_cur;
  logic pri_ok, sec_ok, cur_ok, oth_ok, chat_idle, have_hist;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // one source type for both references, never mixed
  always_comb begin
    q_pri = ext_src ? ext_pri : trunk_pri;
    q_sec = ext_src ? ext_sec : trunk_sec;
    pri_ok = q_pri.present & q_pri.in_spec & ~q_pri.burst;
    sec_ok = q_sec.present & q_sec.in_spec & ~q_sec.burst;
    q_cur = sel ? q_sec : q_pri;
    cur_ok = sel ? sec_ok : pri_ok;
    oth_ok = sel ? pri_ok : sec_ok;
    chat_idle = (chat_cnt == 64'h0);
    have_hist = (hist_fill != '0);
  end

  // quality history: one sample per cycle, ring of HIST_DEPTH
  crs_hist_mem u_hist (
    .clk(ref_clk),
    .rst_n(rst_s2),
    .wr_en(phase == ST_RUN),
    .addr(hist_ptr),
    .wr_data({sec_ok, pri_ok}),
    .rd_data(hist_rd)
  );

  // main mode, selection, chatter, self-test and watchdog next state
  always_comb begin
    next_phase = phase;
    next_mode = mode;
    next_cur_cmd = cur_cmd;
    next_sel = sel;
    next_chat_cnt = chat_idle ? chat_cnt : chat_cnt - 64'h1;
    next_st_cnt = st_cnt;
    next_t_done = t_done;
    next_t_fail = t_fail;
    next_lock_cnt = lock_cnt;
    next_hist_ptr = hist_ptr;
    next_hist_fill = hist_fill;
    // watchdog counts down unless kicked; expiry pulses a controller reset
    next_wd_rst = 1'b0;
    next_wd_cnt = wdog_kick ? WDOG_CYCLES : wd_cnt - 32'h1;
    if (wd_cnt == 32'h0 && !wdog_kick) begin
      next_wd_rst = 1'b1;
      next_wd_cnt = WDOG_CYCLES;
    end
    unique case (phase)
      ST_SELFTEST: begin
        // references are ignored until the self-test finishes
        next_st_cnt = st_cnt + 5'h1;
        if (!test_pass) begin
          next_t_fail = 1'b1;
        end
        if (st_cnt == 5'(SELFTEST_CYC - 1)) begin
          next_t_done = 1'b1;
          next_phase = ST_RUN;
        end
      end
      ST_RUN: begin
        next_hist_ptr = hist_ptr + 1'b1;
        if (hist_fill != ($clog2(HIST_DEPTH)+1)'(HIST_DEPTH)) begin
          next_hist_fill = hist_fill + 1'b1;
        end
        if (cmd_valid && cmd != CMD_NONE) begin
          next_cur_cmd = cmd;
          if (cmd == CMD_FREE_RUN) begin
            next_mode = MODE_FREE_RUN;
          end else begin
            next_sel = (cmd == CMD_TRACK_SEC);
            next_mode = MODE_TRACKING;
            next_lock_cnt = 7'h0;
          end
        end else if (cur_cmd == CMD_FREE_RUN) begin
          next_mode = MODE_FREE_RUN;
        end else if (!pri_ok && !sec_ok) begin
          // holdover needs history; no chatter wait on entry
          next_mode = have_hist ? MODE_HOLDOVER : MODE_FREE_RUN;
        end else if (mode == MODE_HOLDOVER || mode == MODE_FREE_RUN) begin
          // leave holdover on whichever recovered first
          next_sel = !pri_ok;
          next_mode = MODE_TRACKING;
          next_lock_cnt = 7'h0;
          if (next_sel != sel) begin
            next_chat_cnt = CHATTER_CYCLES;
          end
        end else if (!cur_ok && oth_ok && chat_idle) begin
          next_sel = ~sel;
          next_chat_cnt = CHATTER_CYCLES;
          next_mode = MODE_TRACKING;
          next_lock_cnt = 7'h0;
        end else if (chat_idle && (sel != (cur_cmd == CMD_TRACK_SEC))
                     && (sel ? pri_ok : sec_ok)) begin
          // commanded reference is back: return to it
          next_sel = ~sel;
          next_chat_cnt = CHATTER_CYCLES;
          next_mode = MODE_TRACKING;
          next_lock_cnt = 7'h0;
        end else if (cur_ok) begin
          // converge then lock; lost near_lock drops back to tracking
          if (!q_cur.near_lock) begin
            next_lock_cnt = 7'h0;
            next_mode = MODE_TRACKING;
          end else if (lock_cnt == 7'(LOCK_CYC - 1)) begin
            next_mode = MODE_LOCKED;
          end else begin
            next_lock_cnt = lock_cnt + 7'h1;
          end
        end
      end
    endcase
    if (!enable) begin
      next_mode = MODE_FREE_RUN;
      next_cur_cmd = CMD_FREE_RUN;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      phase <= ST_SELFTEST;
      mode <= MODE_FREE_RUN;
      cur_cmd <= CMD_FREE_RUN;
      sel <= 1'b0;
      chat_cnt <= 64'h0;
      wd_cnt <= 32'(WDOG_CYCLES);
      wd_rst <= 1'b0;
      st_cnt <= 5'h0;
      t_done <= 1'b0;
      t_fail <= 1'b0;
      lock_cnt <= 7'h0;
      hist_ptr <= '0;
      hist_fill <= '0;
    end else begin
      phase <= next_phase;
      mode <= next_mode;
      cur_cmd <= next_cur_cmd;
      sel <= next_sel;
      chat_cnt <= next_chat_cnt;
      wd_cnt <= next_wd_cnt;
      wd_rst <= next_wd_rst;
      st_cnt <= next_st_cnt;
      t_done <= next_t_done;
      t_fail <= next_t_fail;
      lock_cnt <= next_lock_cnt;
      hist_ptr <= next_hist_ptr;
      hist_fill <= next_hist_fill;
    end
  end

  // outputs
  always_comb begin
    status = '{mode: mode, sel_sec: sel, pri_ok: pri_ok, sec_ok: sec_ok,
               test_done: t_done, test_fail: t_fail};
    sel_sec = sel;
    hold_en = (mode == MODE_HOLDOVER);
    // drive the shared line whenever trunk primary is selected after self-test, in any mode
    primary_ref_backplane_line_oe = !ext_src && !sel && phase == ST_RUN;
    ctrl_reset = wd_rst;
  end

  // hist_rd kept for future aging checks of the oldest sample
  logic unused_hist;
  assign unused_hist = ^hist_rd;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_s2);

  sequence s_fail_over;
    mode inside {MODE_TRACKING, MODE_LOCKED} && !cur_ok && oth_ok && chat_idle
      && cur_cmd != CMD_FREE_RUN && !cmd_valid && enable;
  endsequence

  auto_switch_a: assert property (s_fail_over |=> $changed(sel))
    else $error("no automatic switchover");
  // leaving holdover or free-run and commands are not chatter-limited
  chatter_gap_a: assert property ($changed(sel) && !$past(cmd_valid)
      |=> ($stable(sel) || $past(cmd_valid) || !$past(enable)
           || $past(mode) inside {MODE_HOLDOVER, MODE_FREE_RUN}) [*8])
    else $error("switchover inside chatter window");
  hold_entry_a: assert property (phase == ST_RUN && !pri_ok && !sec_ok && have_hist
      && cur_ok == 1'b0 && cur_cmd != CMD_FREE_RUN && !cmd_valid && enable
      |=> mode == MODE_HOLDOVER)
    else $error("holdover not entered");
  free_hold_a: assert property (cur_cmd == CMD_FREE_RUN && !cmd_valid
      |=> mode == MODE_FREE_RUN)
    else $error("free-run left without command");
  disable_free_a: assert property (!enable |=> mode == MODE_FREE_RUN)
    else $error("not free-run after disable");
  wdog_fire_a: assert property (wd_cnt == 32'h0 && !wdog_kick |=> ctrl_reset)
    else $error("watchdog did not fire");
  selftest_first_a: assert property (!t_done |-> mode == MODE_FREE_RUN || !enable
      || phase == ST_SELFTEST)
    else $error("reference handling before self-test");
  line_own_a: assert property (primary_ref_backplane_line_oe |-> !sel && !ext_src)
    else $error("backplane line driven while not on primary");
  lock_path_a: assert property ($rose(mode == MODE_LOCKED)
      |-> $past(mode) == MODE_TRACKING)
    else $error("locked without tracking");
endmodule

// >>> test/crs_ref_model.sv
// crs_ref_model: behavioural far-side reference source, trunk card or external timing
// assumes the bench steers good, burst and near just after ref_clk rising edges
`timescale 1ns/1ps
module crs_ref_model
  import crs_pkg::*;
(
  input wire logic good,  // reference within spec
  input wire logic burst, // error burst on the line
  input wire logic near,  // frequency close enough to lock
  output crs_ref_qual_t q // quality seen by the selector
);
  // a lost reference drops presence; a burst keeps carrier but spoils it
  assign q.present = good | burst;
  assign q.in_spec = good & ~burst;
  assign q.burst = burst;
  assign q.near_lock = good & near;
endmodule

// >>> test/clock_reference_selector_tb.sv
// clock_reference_selector_tb: directed scenarios for the reference selector
// assumes short chatter and watchdog counts; reference models stand in for the cards
`timescale 1ns/1ps
module clock_reference_selector_tb
  import crs_pkg::*;
;
  localparam logic [2:0] G = 3'h5; // good and near lock
  localparam logic [2:0] B = 3'h0; // lost
  localparam logic [2:0] E = 3'h2; // error burst
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic ext_src = 1'b0;
  logic enable = 1'b1;
  logic kick_on = 1'b1;
  logic wdog_kick = 1'b0;
  crs_cmd_t cmd = CMD_NONE;
  logic [2:0] tp = B, ts = B, ep = B, es = B;
  crs_ref_qual_t trunk_pri, trunk_sec, ext_pri, ext_sec;
  crs_status_t status;
  logic sel_sec, hold_en, oe, ctrl_reset;
  int mismatches = 0;
  int tests_run = 0;

  crs_ref_model i_tp (.good(tp[2]), .burst(tp[1]), .near(tp[0]), .q(trunk_pri));
  crs_ref_model i_ts (.good(ts[2]), .burst(ts[1]), .near(ts[0]), .q(trunk_sec));
  crs_ref_model i_ep (.good(ep[2]), .burst(ep[1]), .near(ep[0]), .q(ext_pri));
  crs_ref_model i_es (.good(es[2]), .burst(es[1]), .near(es[0]), .q(ext_sec));

  crs_selector #(.CHATTER_CYCLES(20), .WDOG_CYCLES(50)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .enable(enable), .cmd_valid(cmd_valid), .cmd(cmd),
    .ext_src(ext_src), .trunk_pri(trunk_pri), .trunk_sec(trunk_sec), .ext_pri(ext_pri),
    .ext_sec(ext_sec), .wdog_kick(wdog_kick), .test_pass(1'b1), .status(status),
    .sel_sec(sel_sec), .hold_en(hold_en), .primary_ref_backplane_line_oe(oe),
    .ctrl_reset(ctrl_reset)
  );

  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // controller service pulses every other cycle while kicking is on
  always @(posedge ref_clk) begin
    wdog_kick <= kick_on & ~wdog_kick;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic send(input crs_cmd_t c);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd <= CMD_NONE;
    cyc(2);
  endtask

  // both references change together, then settle
  task automatic refs(input logic [2:0] p, input logic [2:0] s);
    @(posedge ref_clk);
    tp <= p;
    ts <= s;
    cyc(3);
  endtask

  // bounded wait for a status field; running out ends the run
  task automatic wait_st(input logic [6:0] mask, input logic [6:0] val, input int lim);
    int n;
    n = 0;
    while ((status & mask) !== val && n < lim) begin
      cyc(1);
      n++;
    end
    check(8'(status & mask), 8'(val));
    if ((status & mask) !== val) test_done();
  endtask

  task automatic t_start();
    cyc(8);
    check(8'(status.mode), 8'(MODE_FREE_RUN));
    @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_st(7'h02, 7'h02, 40);
    check({7'h0, status.test_fail}, 8'h0);
    check(8'(status.mode), 8'(MODE_FREE_RUN));
  endtask

  task automatic t_track_pri();
    refs(G, G);
    send(CMD_TRACK_PRI);
    check({6'h0, sel_sec, oe}, 8'h1);
    check(8'(status.mode), 8'(MODE_TRACKING));
    wait_st(7'h60, {MODE_LOCKED, 5'h0}, 100);
    refs(B, G);
    check({6'h0, sel_sec, oe}, 8'h2);
    check(8'({status.pri_ok, status.sec_ok}), 8'h1);
    refs(B, B);
    check({6'h0, status.mode == MODE_HOLDOVER, hold_en}, 8'h3);
    refs(B, G);
    check({7'h0, sel_sec}, 8'h1);
    refs(G, G);
    check({7'h0, sel_sec}, 8'h1);
    wait_st(7'h10, 7'h00, 40);
  endtask

  task automatic t_burst();
    refs(E, B);
    check({7'h0, hold_en}, 8'h1);
    refs(G, B);
    refs(G, G);
    cyc(40);
    check({7'h0, sel_sec}, 8'h0);
  endtask

  task automatic t_track_sec();
    send(CMD_TRACK_SEC);
    check({7'h0, sel_sec}, 8'h1);
    refs(G, B);
    check({7'h0, sel_sec}, 8'h0);
    refs(B, B);
    refs(B, G);
    refs(G, G);
    cyc(40);
    check({7'h0, sel_sec}, 8'h1);
    refs(B, B);
    refs(G, B);
    check({7'h0, sel_sec}, 8'h0);
    refs(G, G);
    wait_st(7'h10, 7'h10, 40);
  endtask

  // trunk refs stay good; only the external pair decides
  task automatic t_ext();
    @(posedge ref_clk);
    ep <= G;
    es <= B;
    ext_src <= 1'b1;
    wait_st(7'h10, 7'h00, 40);
    check({7'h0, oe}, 8'h0);
    @(posedge ref_clk);
    ext_src <= 1'b0;
  endtask

  task automatic t_free();
    send(CMD_FREE_RUN);
    check(8'(status.mode), 8'(MODE_FREE_RUN));
    cyc(40);
    check(8'(status.mode), 8'(MODE_FREE_RUN));
    // disable forces free-run whatever the command
    @(posedge ref_clk);
    enable <= 1'b0;
    cyc(2);
    check(8'(status.mode), 8'(MODE_FREE_RUN));
    @(posedge ref_clk);
    enable <= 1'b1;
  endtask

  task automatic t_wdog();
    int n;
    check({7'h0, ctrl_reset}, 8'h0);
    @(posedge ref_clk);
    kick_on <= 1'b0;
    n = 0;
    while (ctrl_reset !== 1'b1 && n < 70) begin
      cyc(1);
      n++;
    end
    check({7'h0, ctrl_reset}, 8'h1);
    if (ctrl_reset !== 1'b1) test_done();
    kick_on <= 1'b1;
  endtask

  initial begin
    t_start();
    t_track_pri();
    t_burst();
    t_track_sec();
    t_ext();
    t_free();
    t_wdog();
    test_done();
  end
endmodule
